// File: src/lpsr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lpsr_ctrl
  import lpsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  lpsr_if.ctrl mem
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_PDED = 3'b001,
    C_SR = 3'b011,
    C_XSR = 3'b010,
    C_REF = 3'b100,
    C_MRW = 3'b101
  } lpsr_cstate_t;

  lpsr_cstate_t state_r;
  logic [11:0] timer_r;
  logic [11:0] refi_cnt_r;
  logic signed [4:0] owed_r;
  logic [2:0] pb_cnt_r;
  logic need_ref_r;
  logic [2:0] ctrl_r;
  logic [7:0] bmask_r;
  logic [7:0] smask_r;
  logic bmask_pend_r;
  logic smask_pend_r;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic w_lane0_r;
  logic wr_fire;
  logic in_sr;
  logic refi_tick;
  logic use_pb;
  logic go_ref;
  logic go_mrw;
  logic go_sr;
  logic round_done;
  logic [31:0] rd_word;
  logic rd_hit;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_lane0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == REG_CTRL || aw_addr_r == REG_STATUS ||
                        aw_addr_r == REG_BMASK || aw_addr_r == REG_SMASK)
                       ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;

  // read data selection
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      REG_CTRL: rd_word = {29'h0, ctrl_r};
      REG_STATUS: rd_word = {19'h0, need_ref_r, pb_cnt_r, in_sr, state_r,
                             owed_r};
      REG_BMASK: rd_word = {24'h0, bmask_r};
      REG_SMASK: rd_word = {24'h0, smask_r};
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel: one read at a time, answer the cycle after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control and mask registers; a new write beats a pending clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      bmask_r <= MASK_RST;
      smask_r <= MASK_RST;
      bmask_pend_r <= 1'b0;
      smask_pend_r <= 1'b0;
    end else begin
      if (go_mrw && bmask_pend_r) begin
        bmask_pend_r <= 1'b0;
      end else if (go_mrw) begin
        smask_pend_r <= 1'b0;
      end
      if (wr_fire && w_lane0_r) begin
        if (aw_addr_r == REG_CTRL) begin
          ctrl_r <= w_data_r[2:0];
        end
        if (aw_addr_r == REG_BMASK) begin
          bmask_r <= w_data_r[7:0];
          bmask_pend_r <= 1'b1;
        end
        if (aw_addr_r == REG_SMASK) begin
          smask_r <= w_data_r[7:0];
          smask_pend_r <= 1'b1;
        end
      end
    end
  end

  // scheduling decisions, taken only when idle
  assign in_sr = (state_r == C_PDED) || (state_r == C_SR) ||
                 (state_r == C_XSR);
  assign use_pb = ctrl_r[2];
  assign refi_tick = !in_sr && (refi_cnt_r == 12'(REFI_CYC - 1));
  always_comb begin
    go_ref = 1'b0;
    go_mrw = 1'b0;
    go_sr = 1'b0;
    if (state_r == C_IDLE) begin
      if (owed_r >= CREDIT_MAX) begin
        go_ref = 1'b1;
      end else if (bmask_pend_r || smask_pend_r) begin
        go_mrw = 1'b1;
      end else if (ctrl_r[0] && need_ref_r) begin
        go_ref = 1'b1;
      end else if (ctrl_r[0] && owed_r <= CREDIT_MAX) begin
        go_sr = 1'b1;
      end else if (ctrl_r[1] && owed_r > 5'sh00) begin
        go_ref = 1'b1;
      end
    end
  end
  assign round_done = go_ref && (!use_pb || pb_cnt_r == LAST_BANK);

  // average interval timer, stopped while asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refi_cnt_r <= '0;
    end else if (refi_tick) begin
      refi_cnt_r <= '0;
    end else if (!in_sr) begin
      refi_cnt_r <= refi_cnt_r + 12'h001;
    end
  end

  // signed credit: positive is owed, negative is pulled in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owed_r <= '0;
    end else if (refi_tick && !round_done) begin
      if (owed_r < CREDIT_MAX) begin
        owed_r <= owed_r + 5'sh01;
      end
    end else if (round_done && !refi_tick) begin
      if (owed_r > CREDIT_MIN) begin
        owed_r <= owed_r - 5'sh01;
      end
    end
  end

  // bank counter mirror and refresh-after-exit flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_cnt_r <= '0;
      need_ref_r <= 1'b0;
    end else if (state_r == C_SR && timer_r == '0 && !ctrl_r[0]) begin
      pb_cnt_r <= '0;
      need_ref_r <= 1'b1;
    end else if (go_ref) begin
      pb_cnt_r <= use_pb ? pb_cnt_r + 3'h1 : 3'h0;
      if (round_done) begin
        need_ref_r <= 1'b0;
      end
    end
  end

  // command sequencer driving the memory pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= C_IDLE;
      timer_r <= '0;
      mem.cke <= 1'b1;
      mem.cs_n <= 1'b1;
      mem.ca <= CA_NOP;
      mem.ma <= '0;
      mem.op <= '0;
    end else begin
      mem.cs_n <= 1'b1; // nop unless a command below
      mem.ca <= CA_NOP;
      case (state_r)
        C_IDLE: begin
          if (go_ref) begin
            mem.cs_n <= 1'b0;
            mem.ca <= use_pb ? CA_REF_PB : CA_REF_AB;
            timer_r <= use_pb ? 12'(RFCPB_CYC - 1) : 12'(RFC_CYC - 1);
            state_r <= C_REF;
          end else if (go_mrw) begin
            mem.cs_n <= 1'b0;
            mem.ca <= CA_MRW;
            mem.ma <= bmask_pend_r ? MA_BANK_MASK : MA_SEG_MASK;
            mem.op <= bmask_pend_r ? bmask_r : smask_r;
            timer_r <= 12'(MRW_CYC - 1);
            state_r <= C_MRW;
          end else if (go_sr) begin
            // enable was high last cycle since idle keeps it high
            mem.cke <= 1'b0;
            mem.cs_n <= 1'b0;
            mem.ca <= CA_SREF;
            timer_r <= 12'(CPDED_CYC - 1);
            state_r <= C_PDED;
          end
        end
        C_REF, C_MRW: begin
          if (timer_r != '0) begin
            timer_r <= timer_r - 12'h001;
          end else begin
            state_r <= C_IDLE;
          end
        end
        C_PDED: begin
          if (timer_r != '0) begin
            timer_r <= timer_r - 12'h001;
          end else begin
            timer_r <= 12'(SR_HOLD_CYC - 1);
            state_r <= C_SR;
          end
        end
        C_SR: begin
          if (timer_r != '0) begin
            timer_r <= timer_r - 12'h001;
          end else if (!ctrl_r[0]) begin
            mem.cke <= 1'b1;
            timer_r <= 12'(XSR_CYC - 1);
            state_r <= C_XSR;
          end else begin
            mem.cke <= 1'b0;
          end
        end
        C_XSR: begin
          if (timer_r != '0) begin
            timer_r <= timer_r - 12'h001;
          end else begin
            state_r <= C_IDLE;
          end
        end
        default: begin
          state_r <= C_IDLE;
          mem.cke <= 1'b1;
        end
      endcase
    end
  end
endmodule : lpsr_ctrl
`default_nettype wire

// File: src/lpsr_pkg.sv
package lpsr_pkg;
  // clock and timing figures
  localparam int CLK_MHZ = 200;
  localparam int RFC_NS = 210;
  localparam int RFCPB_NS = 90;
  localparam int REFI_NS = 3900;
  localparam int XSR_NS = 220;
  localparam int CKESR_NS = 15;
  localparam int MRW_NS = 50;
  // least times round up, the longest interval rounds down
  localparam int RFC_CYC = (RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int RFCPB_CYC = (RFCPB_NS * CLK_MHZ + 999) / 1000;
  localparam int REFI_CYC = (REFI_NS * CLK_MHZ) / 1000;
  localparam int XSR_CYC = (XSR_NS * CLK_MHZ + 999) / 1000;
  localparam int CKESR_CYC = (CKESR_NS * CLK_MHZ + 999) / 1000;
  localparam int MRW_CYC = (MRW_NS * CLK_MHZ + 999) / 1000;
  localparam int CPDED_CYC = 2;
  localparam int EXIT_CLK_CYC = 2;
  localparam int SR_HOLD_CYC = (CKESR_CYC > EXIT_CLK_CYC) ? CKESR_CYC
                                                          : EXIT_CLK_CYC;
  // refresh credit bounds
  localparam logic signed [4:0] CREDIT_MAX = 5'sh08;
  localparam logic signed [4:0] CREDIT_MIN = -5'sh08;
  localparam logic [2:0] LAST_BANK = 3'h7;
  // command bits 3..0
  localparam logic [3:0] CA_NOP = 4'h7;
  localparam logic [3:0] CA_MRW = 4'h0;
  localparam logic [3:0] CA_REF_AB = 4'hc;
  localparam logic [3:0] CA_REF_PB = 4'h4;
  localparam logic [3:0] CA_SREF = 4'h4;
  localparam logic [2:0] CA_REF_LO = 3'h4;
  // mode register addresses and reset values
  localparam logic [7:0] MA_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_SEG_MASK = 8'h11;
  localparam logic [7:0] MASK_RST = 8'h00;
  // controller register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BMASK = 8'h08;
  localparam logic [7:0] REG_SMASK = 8'h0c;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lpsr_pkg

// File: src/lpsr_if.sv
`timescale 1ns/1ps
`default_nettype none
// command, address and clock enable from controller to memory die
interface lpsr_if;
  logic cke;
  logic cs_n;
  logic [3:0] ca;
  logic [7:0] ma;
  logic [7:0] op;
  modport ctrl (output cke, output cs_n, output ca, output ma, output op);
  modport mem (input cke, input cs_n, input ca, input ma, input op);
endinterface : lpsr_if
`default_nettype wire

// File: src/lpsr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module lpsr_mem
  import lpsr_pkg::*;
#(
  parameter int SR_REF_CYCLES = REFI_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  lpsr_if.mem pins,
  output logic self_refresh,
  output logic receivers_on,
  output logic [2:0] bank_ptr,
  output logic ref_strobe,
  output logic [7:0] ref_banks,
  output logic [7:0] ref_segs,
  output logic [7:0] bank_mask,
  output logic [7:0] seg_mask
);
  typedef enum logic [1:0] {
    D_ACT = 2'b00,
    D_PDED = 2'b01,
    D_SR = 2'b11,
    D_XSR = 2'b10
  } lpsr_dstate_t;

  lpsr_dstate_t state_r;
  logic [11:0] cnt_r;
  logic cke_prev_r;
  logic is_ref;
  logic sre_hit;
  logic cmd_live;

  // one-hot bank select for a per-bank refresh
  function automatic logic [7:0] lpsr_bank_bit(input logic [2:0] b);
    lpsr_bank_bit = 8'h01 << b;
  endfunction : lpsr_bank_bit

  // command decode; inputs only count while awake and out of exit delay
  assign is_ref = !pins.cs_n && (pins.ca[2:0] == CA_REF_LO);
  assign sre_hit = (state_r == D_ACT) && cke_prev_r && !pins.cke && is_ref;
  assign cmd_live = (state_r == D_ACT) && pins.cke && !pins.cs_n;

  // previous clock enable for entry detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_prev_r <= 1'b1;
    end else begin
      cke_prev_r <= pins.cke;
    end
  end

  // power state, internal refresh timer and refresh strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= D_ACT;
      cnt_r <= '0;
      self_refresh <= 1'b0;
      receivers_on <= 1'b1;
      ref_strobe <= 1'b0;
      ref_banks <= '0;
      ref_segs <= '0;
    end else begin
      ref_strobe <= 1'b0;
      case (state_r)
        D_ACT: begin
          if (sre_hit) begin
            state_r <= D_PDED;
            self_refresh <= 1'b1;
            cnt_r <= 12'(CPDED_CYC - 1);
          end else if (cmd_live && is_ref) begin
            ref_strobe <= 1'b1;
            ref_banks <= pins.ca[3] ? 8'hff : lpsr_bank_bit(bank_ptr);
            ref_segs <= 8'hff;
          end
        end
        D_PDED: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 12'h001;
          end else begin
            state_r <= D_SR;
            receivers_on <= 1'b0;
            // first internal refresh at once, well inside residency
            ref_strobe <= 1'b1;
            ref_banks <= ~bank_mask;
            ref_segs <= ~seg_mask;
            cnt_r <= 12'(SR_REF_CYCLES - 1);
          end
        end
        D_SR: begin
          if (pins.cke) begin
            state_r <= D_XSR;
            receivers_on <= 1'b1;
            cnt_r <= 12'(XSR_CYC - 1);
          end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 12'h001;
          end else begin
            ref_strobe <= 1'b1;
            ref_banks <= ~bank_mask;
            ref_segs <= ~seg_mask;
            cnt_r <= 12'(SR_REF_CYCLES - 1);
          end
        end
        D_XSR: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 12'h001;
          end else begin
            state_r <= D_ACT;
            self_refresh <= 1'b0;
          end
        end
        default: begin
          state_r <= D_ACT;
        end
      endcase
    end
  end

  // per-bank counter; internal refreshes leave it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_ptr <= '0;
    end else if (state_r == D_SR && pins.cke) begin
      bank_ptr <= '0;
    end else if (cmd_live && is_ref) begin
      bank_ptr <= pins.ca[3] ? 3'h0 : bank_ptr + 3'h1;
    end
  end

  // mode register writes to the retention masks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_mask <= MASK_RST;
      seg_mask <= MASK_RST;
    end else if (cmd_live && pins.ca == CA_MRW) begin
      if (pins.ma == MA_BANK_MASK) begin
        bank_mask <= pins.op;
      end
      if (pins.ma == MA_SEG_MASK) begin
        seg_mask <= pins.op;
      end
    end
  end
endmodule : lpsr_mem
`default_nettype wire

// File: tb/lpsr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lpsr_properties
  import lpsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [3:0] ca,
  input wire logic [7:0] ma,
  input wire logic [7:0] op
);
  localparam int MAX_GAP = 9 * REFI_CYC;
  logic cke_q_r;
  logic last_ab_r;
  logic last_pb_r;
  logic [7:0] gap_r;
  logic [7:0] xsr_r;
  logic [12:0] ref_gap_r;
  logic cmd;
  logic nop;
  logic ref_cmd;
  // a command needs the die awake on the previous edge
  assign cmd = !cs_n && cke_q_r && ca[2:0] != CA_NOP[2:0];
  assign nop = cs_n || ca[2:0] == CA_NOP[2:0];
  assign ref_cmd = cmd && cke && ca[2:0] == CA_REF_LO;
  // clock enable of the previous edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_q_r <= 1'b1;
    end else begin
      cke_q_r <= cke;
    end
  end
  // cycles since the last command, and what it was
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 8'hff;
      last_ab_r <= 1'b0;
      last_pb_r <= 1'b0;
    end else if (cmd) begin
      gap_r <= 8'h00;
      last_ab_r <= cke && ca == CA_REF_AB;
      last_pb_r <= cke && ca == CA_REF_PB;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end
  // cycles since clock enable came back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xsr_r <= 8'hff;
    end else if (cke && !cke_q_r) begin
      xsr_r <= 8'h00;
    end else if (xsr_r != 8'hff) begin
      xsr_r <= xsr_r + 8'h01;
    end
  end
  // awake cycles since the last refresh; sleep does not count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_gap_r <= 13'h0000;
    end else if (ref_cmd) begin
      ref_gap_r <= 13'h0000;
    end else if (cke && ref_gap_r != 13'h1fff) begin
      ref_gap_r <= ref_gap_r + 13'h0001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rfc_ab;
    cmd && last_ab_r |-> gap_r >= RFC_CYC - 1;
  endproperty
  a_rfc_ab: assert property (p_rfc_ab)
    else $error("command too soon after all-bank refresh");
  property p_rfc_pb;
    cmd && last_pb_r |-> gap_r >= RFCPB_CYC - 1;
  endproperty
  a_rfc_pb: assert property (p_rfc_pb)
    else $error("command too soon after per-bank refresh");
  property p_ref_gap;
    ref_gap_r <= MAX_GAP;
  endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("refresh gap too long");
  property p_entry_code;
    $fell(cke) |-> !cs_n && ca[2:0] == CA_REF_LO;
  endproperty
  a_entry_code: assert property (p_entry_code)
    else $error("enable fell without sleep command");
  property p_entry_prev;
    !cke && !cs_n |-> $past(cke);
  endproperty
  a_entry_prev: assert property (p_entry_prev)
    else $error("sleep command without enable high before");
  property p_pded;
    $fell(cke) |=> (nop && !cke)[*2];
  endproperty
  a_pded: assert property (p_pded)
    else $error("no two nops after enable fell");
  property p_quiet;
    !cke && !$past(cke) |-> cs_n;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("select driven while asleep");
  property p_residency;
    $fell(cke) |-> !cke[*3];
  endproperty
  a_residency: assert property (p_residency)
    else $error("sleep shorter than residency");
  property p_exit_hold;
    $rose(cke) |-> (cke && nop)[*8];
  endproperty
  a_exit_hold: assert property (p_exit_hold)
    else $error("enable or nop not held after wake");
  property p_exit_delay;
    cke && cmd |-> xsr_r >= XSR_CYC - 1;
  endproperty
  a_exit_delay: assert property (p_exit_delay)
    else $error("command inside exit delay");
  property p_mrw_addr;
    cmd && cke && ca == CA_MRW |-> ma == MA_BANK_MASK || ma == MA_SEG_MASK;
  endproperty
  a_mrw_addr: assert property (p_mrw_addr)
    else $error("mode write to unknown address");
endmodule : lpsr_properties
`default_nettype wire

// File: tb/lpsr_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
`define POLL(c) for (int i = 0; i < 3000 && !(c); i++) @(posedge aclk);
module lpsr_tb
  import lpsr_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0;
  logic [AXI_AW-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, self_refresh, receivers_on, ref_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [2:0] bank_ptr;
  logic [7:0] ref_banks, ref_segs, bank_mask, seg_mask, rb, rs;
  logic [4:0] credit;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  lpsr_if mif ();
  lpsr_ctrl lpsr_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem(mif));
  lpsr_mem #(.SR_REF_CYCLES(20)) lpsr_mem_inst (.aclk, .aresetn,
    .pins(mif), .self_refresh, .receivers_on, .bank_ptr, .ref_strobe,
    .ref_banks, .ref_segs, .bank_mask, .seg_mask);
  lpsr_properties lpsr_properties_inst (.aclk, .aresetn,
    .cke(mif.cke), .cs_n(mif.cs_n), .ca(mif.ca), .ma(mif.ma),
    .op(mif.op));
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // register write, each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, e)
    s_axi_bready <= 1'b0;
  endtask : wr
  // register read into rd_d, response checked
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    `CHK(s_axi_rresp, e)
    s_axi_rready <= 1'b0;
  endtask : rd
  // next refresh seen by the die
  task automatic wait_ref();
    do @(posedge aclk); while (ref_strobe !== 1'b1);
    rb = ref_banks;
    rs = ref_segs;
  endtask : wait_ref
  // reset state and unmapped addresses
  task automatic t_reset();
    `CHK(self_refresh, 1'b0)
    `CHK(bank_ptr, 3'h0)
    `CHK(bank_mask, MASK_RST)
    `CHK(seg_mask, MASK_RST)
    rd(REG_CTRL, RESP_OKAY);
    `CHK(rd_d[2:0], CTRL_RST)
    wr(8'h20, 32'h00000001, RESP_SLVERR);
    rd(8'h30, RESP_SLVERR);
    `CHK(rd_d, 32'h00000000)
  endtask : t_reset
  // mask registers reach the die by mode write
  task automatic t_masks();
    wr(REG_BMASK, 32'h00000082, RESP_OKAY);
    wr(REG_SMASK, 32'h00000084, RESP_OKAY);
    `POLL(seg_mask === 8'h84 && bank_mask === 8'h82)
    `CHK(bank_mask, 8'h82)
    `CHK(seg_mask, 8'h84)
  endtask : t_masks
  // one all-bank refresh, then three per-bank in order
  task automatic t_refresh();
    wr(REG_CTRL, 32'h00000002, RESP_OKAY);
    wait_ref();
    `CHK(rb, 8'hff)
    `CHK(rs, 8'hff)
    wr(REG_CTRL, 32'h00000006, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      wait_ref();
      `CHK(rb, 8'h01 << i)
      `CHK(rs, 8'hff)
    end
  endtask : t_refresh
  // sleep with masks, frozen credit, wake with counter zeroed
  task automatic t_sleep();
    wr(REG_CTRL, 32'h00000005, RESP_OKAY);
    `POLL(self_refresh === 1'b1)
    wait_ref();
    `CHK(rb, 8'h7d)
    `CHK(rs, 8'h7b)
    `POLL(receivers_on === 1'b0)
    `CHK(receivers_on, 1'b0)
    rd(REG_STATUS, RESP_OKAY);
    `CHK(rd_d[8], 1'b1)
    credit = rd_d[4:0];
    repeat (1600) @(posedge aclk);
    rd(REG_STATUS, RESP_OKAY);
    `CHK(rd_d[4:0], credit)
    `CHK(self_refresh, 1'b1)
    wr(REG_CTRL, 32'h00000004, RESP_OKAY);
    `POLL(self_refresh === 1'b0)
    `CHK(bank_ptr, 3'h0)
    `CHK(receivers_on, 1'b1)
    rd(REG_STATUS, RESP_OKAY);
    `CHK(rd_d[12], 1'b1)
    `CHK(rd_d[11:9], 3'h0)
  endtask : t_sleep
  // second sleep must be preceded by a refresh
  task automatic t_resleep();
    wr(REG_CTRL, 32'h00000001, RESP_OKAY);
    wait_ref();
    `CHK(self_refresh, 1'b0)
    `CHK(rb, 8'hff)
    `POLL(self_refresh === 1'b1)
    `CHK(self_refresh, 1'b1)
    wr(REG_CTRL, 32'h00000000, RESP_OKAY);
    `POLL(self_refresh === 1'b0)
    `CHK(self_refresh, 1'b0)
  endtask : t_resleep
  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("ERROR %0t: timeout", $time);
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_masks();
    t_refresh();
    t_sleep();
    t_resleep();
    conclude();
  end
endmodule : lpsr_tb
`default_nettype wire
